//--- hdl/rmh_map.svh
// Offsets, field positions and timing counts of the mask ROM host.
// Assumes a 20 MHz mclk; included by bare name wherever needed.
`ifndef RMH_MAP_SVH
`define RMH_MAP_SVH

// Clock and ROM pin timing
`define RMH_CLK_MHZ      20
`define RMH_CLK_NS       (1000 / `RMH_CLK_MHZ)
`define RMH_T_ACC_NS     350
`define RMH_T_CO_NS      150
`define RMH_T_DHD_NS     150
`define RMH_ACC_CYC      ((`RMH_T_ACC_NS + `RMH_CLK_NS - 1) / `RMH_CLK_NS)
`define RMH_CO_CYC       ((`RMH_T_CO_NS + `RMH_CLK_NS - 1) / `RMH_CLK_NS)
`define RMH_DHD_CYC      ((`RMH_T_DHD_NS + `RMH_CLK_NS - 1) / `RMH_CLK_NS)
`define RMH_SYNC_CYC     2

// Register byte offsets
`define RMH_OFF_CTRL     5'h00
`define RMH_OFF_ADDR     5'h04
`define RMH_OFF_DATA     5'h08
`define RMH_OFF_STAT     5'h0C
`define RMH_OFF_IMG      5'h10
`define RMH_OFF_IMGST    5'h14

// Field positions
`define RMH_CTRL_START   0
`define RMH_CTRL_FIG     1
`define RMH_IMG_RESTART  8
`define RMH_IMG_NIB      9

// Content image layout
`define RMH_ID_MAX       64
`define RMH_LINE_FIGS    64
`define RMH_LINES        32
`define RMH_CHR_CR       8'h0D
`define RMH_CHR_LF       8'h0A

`endif

//--- hdl/rmh_pkg.sv
// Types and helpers of the mask ROM host.
// Assumes nothing beyond a SystemVerilog compiler.
package rmh_pkg;

  // Mask option of one select pin
  typedef enum logic [1:0] {RMH_SEL_HIGH, RMH_SEL_LOW, RMH_SEL_NC} rmh_sel_t;

  // Hex figure test, ASCII 0-9, A-F, a-f
  function automatic logic rmh_is_hex(input logic [7:0] c);
    rmh_is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
              || (c >= 8'h61 && c <= 8'h66);
  endfunction

  // Hex figure value
  function automatic logic [3:0] rmh_hex_val(input logic [7:0] c);
    if (c <= 8'h39) begin
      rmh_hex_val = c[3:0];
    end else begin
      rmh_hex_val = 4'(c[3:0] + 4'h9);
    end
  endfunction

endpackage

//--- hdl/rmh_image_check.sv
// Content image checker: walks an image one character at a time.
// Assumes characters arrive from the register slave on mclk.
`timescale 1ns/100ps
`default_nettype none
`include "rmh_map.svh"

module rmh_image_check
  import rmh_pkg::*;
(
  input  wire logic        mclk,      // System clock
  input  wire logic        sys_rst,   // Sync reset, high
  input  wire logic [7:0]  chr,       // Image character
  input  wire logic        chr_push,  // Character strobe
  input  wire logic        restart,   // Begin a new image
  input  wire logic        nib_mode,  // 2048 x 4 arrangement
  output logic             img_ok,    // Whole image accepted
  output logic             img_err,   // Format fault seen
  output logic [5:0]       img_lines, // Lines completed
  output logic [10:0]      word_addr, // Last word address
  output logic [7:0]       word_data  // Last word value
);

  typedef enum {ST_ID, ST_ID_LF, ST_FIG, ST_LF, ST_DONE, ST_ERR} rmh_img_st_t;

  rmh_img_st_t st;
  logic [6:0]  id_cnt;
  logic [6:0]  fig_cnt;
  logic [11:0] total;
  logic [3:0]  hi_nib;
  logic        is_hex;
  logic [3:0]  val;

  assign is_hex = rmh_is_hex(chr);
  assign val    = rmh_hex_val(chr);

  ////////////////////////////////////////////////////////////////////////
  // Format walk; ident, CR LF, then 32 lines of 64 figures
  always_ff @(posedge mclk) begin
    if (sys_rst || restart) begin
      st        <= ST_ID;
      id_cnt    <= 7'h00;
      fig_cnt   <= 7'h00;
      img_lines <= 6'h00;
    end else if (chr_push) begin
      case (st)
        ST_ID: begin
          if (chr == `RMH_CHR_CR && id_cnt != 7'h00) begin
            st <= ST_ID_LF;
          end else if (chr == `RMH_CHR_CR || chr == `RMH_CHR_LF) begin
            st <= ST_ERR;
          end else if (id_cnt == 7'(`RMH_ID_MAX)) begin
            st <= ST_ERR;
          end else begin
            id_cnt <= 7'(id_cnt + 7'h01);
          end
        end
        ST_ID_LF: begin
          st      <= (chr == `RMH_CHR_LF) ? ST_FIG : ST_ERR;
          fig_cnt <= 7'h00;
        end
        ST_FIG: begin
          if (is_hex && fig_cnt != 7'(`RMH_LINE_FIGS)) begin
            fig_cnt <= 7'(fig_cnt + 7'h01);
          end else if (chr == `RMH_CHR_CR && fig_cnt == 7'(`RMH_LINE_FIGS)) begin
            st <= ST_LF;
          end else begin
            st <= ST_ERR;
          end
        end
        ST_LF: begin
          if (chr != `RMH_CHR_LF) begin
            st <= ST_ERR;
          end else begin
            img_lines <= 6'(img_lines + 6'h01);
            fig_cnt   <= 7'h00;
            st <= (img_lines == 6'(`RMH_LINES - 1)) ? ST_DONE : ST_FIG;
          end
        end
        ST_DONE:  st <= ST_ERR; // Nothing may follow the last line
        default:  st <= ST_ERR;
      endcase
    end
  end

  assign img_ok  = (st == ST_DONE);
  assign img_err = (st == ST_ERR);

  ////////////////////////////////////////////////////////////////////////
  // Word assembly; pairs in byte mode, single figures in nibble mode
  always_ff @(posedge mclk) begin
    if (sys_rst || restart) begin
      total     <= 12'h000;
      hi_nib    <= 4'h0;
      word_addr <= 11'h000;
      word_data <= 8'h00;
    end else if (chr_push && st == ST_FIG && is_hex
                 && fig_cnt != 7'(`RMH_LINE_FIGS)) begin
      total <= 12'(total + 12'h001);
      if (nib_mode) begin
        word_addr <= total[10:0];
        word_data <= {4'h0, val};
      end else if (!total[0]) begin
        hi_nib <= val;
      end else begin
        word_addr <= {1'b0, total[10:1]};
        word_data <= {hi_nib, val};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_id_limit;
    @(posedge mclk) disable iff (sys_rst)
      (chr_push && !restart && st == ST_ID && id_cnt == 7'(`RMH_ID_MAX)
       && chr != `RMH_CHR_CR) |=> img_err;
  endproperty
  a_id_limit: assert property (p_id_limit)
    else $error("identification longer than limit not flagged");

  property p_line_end;
    @(posedge mclk) disable iff (sys_rst)
      (chr_push && !restart && st == ST_FIG && fig_cnt == 7'(`RMH_LINE_FIGS)
       && chr != `RMH_CHR_CR) |=> img_err;
  endproperty
  a_line_end: assert property (p_line_end)
    else $error("line without CR LF not flagged");

  property p_nib_word;
    @(posedge mclk) disable iff (sys_rst)
      (chr_push && !restart && nib_mode && st == ST_FIG && is_hex
       && fig_cnt != 7'(`RMH_LINE_FIGS))
      |=> word_data == {4'h0, $past(val)} && word_addr == $past(total[10:0]);
  endproperty
  a_nib_word: assert property (p_nib_word)
    else $error("nibble word placed wrongly");

endmodule
`default_nettype wire

//--- hdl/rmh_rom_host.sv
// Host controller for a 1024 x 8 mask ROM with four mask-set selects.
// Assumes an Avalon-MM master on mclk and the ROM on asynchronous pins.
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rmh_map.svh"

// Contract
// - Unconnected selects occupy only the highest positions, with no gap.
// - Image byte is two figures: first D7-D4, second D3-D0.
// - Image is 32 lines of 64 figures, ascending, first line bytes 0-31.
// - In 2048 x 4 arrangement each figure is one word on D3-D0.
// - At most 64 ident characters, ended by CR LF, never leading CR/LF.
// - Every data line, the last too, ends with CR then LF.
module rmh_rom_host
  import rmh_pkg::*;
#(
  parameter rmh_sel_t SEL_ONE_CFG   = RMH_SEL_HIGH, // Mask level of select one
  parameter rmh_sel_t SEL_TWO_CFG   = RMH_SEL_LOW,  // Mask level of select two
  parameter rmh_sel_t SEL_THREE_CFG = RMH_SEL_NC,   // Mask level of select three
  parameter rmh_sel_t SEL_FOUR_CFG  = RMH_SEL_NC    // Mask level of select four
)(
  input  wire logic        mclk,               // 20 MHz clock
  input  wire logic        sys_rst,            // Sync reset, high
  input  wire logic [4:0]  avs_address,        // Byte address
  input  wire logic        avs_read,           // Read request
  input  wire logic        avs_write,          // Write request
  input  wire logic [31:0] avs_writedata,      // Write data
  output logic [31:0]      avs_readdata,       // Read data
  output logic             avs_waitrequest,    // Stall
  output logic [9:0]       rom_addr,           // ROM address pins
  output logic             select_input_one,   // ROM select 1
  output logic             select_input_two,   // ROM select 2
  output logic             select_input_three, // ROM select 3
  output logic             select_input_four,  // ROM select 4
  input  wire logic [7:0]  rom_data            // ROM data pins
);

  typedef enum {PH_IDLE, PH_ACCESS, PH_HOLD} rmh_phase_t;

  // Select pin level for a mask option
  function automatic logic sel_level(input rmh_sel_t cfg, input logic act);
    case (cfg)
      RMH_SEL_HIGH: sel_level = act;
      RMH_SEL_LOW:  sel_level = ~act;
      default:      sel_level = 1'b0; // Unconnected pin, any level
    endcase
  endfunction

  rmh_phase_t  phase;
  logic [3:0]  wait_cnt;
  logic        ack;
  logic        take;
  logic        req;
  logic [10:0] index;
  logic        fig_mode;
  logic        start;
  logic        done;
  logic [7:0]  byte_q;
  logic [3:0]  fig_q;
  logic [10:0] index_q;
  logic [7:0]  data_s1;
  logic [7:0]  data_s2;
  logic        sel_act;
  logic        cfg_ok;
  logic        img_push;
  logic        img_restart;
  logic        img_nib;
  logic        img_ok;
  logic        img_err;
  logic [5:0]  img_lines;
  logic [10:0] word_addr;
  logic [7:0]  word_data;
  logic [31:0] next_readdata;

  ////////////////////////////////////////////////////////////////////////
  // Select order check; a gap below a connected select is a bad mask
  assign cfg_ok = (SEL_ONE_CFG != RMH_SEL_NC)
               && !(SEL_TWO_CFG == RMH_SEL_NC && SEL_THREE_CFG != RMH_SEL_NC)
               && !(SEL_THREE_CFG == RMH_SEL_NC && SEL_FOUR_CFG != RMH_SEL_NC);

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave; one wait state, so read data come from a flop
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign take            = req & ack;
  assign start    = take && avs_write && avs_address == `RMH_OFF_CTRL
                 && avs_writedata[`RMH_CTRL_START] && phase == PH_IDLE;
  assign img_push = take && avs_write && avs_address == `RMH_OFF_IMG;
  assign img_restart = img_push && avs_writedata[`RMH_IMG_RESTART];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Read mux, sampled in the stall cycle
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `RMH_OFF_CTRL:  next_readdata = {30'h0, fig_mode, 1'b0};
      `RMH_OFF_ADDR:  next_readdata = {21'h0, index};
      `RMH_OFF_DATA:  next_readdata = {9'h0, index_q[5:0], index_q[10:6], fig_q, byte_q};
      `RMH_OFF_STAT:  next_readdata = {29'h0, cfg_ok, done, phase != PH_IDLE};
      `RMH_OFF_IMG:   next_readdata = {22'h0, img_nib, 9'h0};
      `RMH_OFF_IMGST: next_readdata = {5'h0, word_data, word_addr, img_lines, img_err, img_ok};
      default:        next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= next_readdata;
    end
  end

  // Control registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      index    <= 11'h000;
      fig_mode <= 1'b0;
      img_nib  <= 1'b0;
    end else if (take && avs_write) begin
      if (avs_address == `RMH_OFF_ADDR && phase == PH_IDLE) begin
        index <= avs_writedata[10:0];
      end
      if (avs_address == `RMH_OFF_CTRL && phase == PH_IDLE) begin
        fig_mode <= avs_writedata[`RMH_CTRL_FIG];
      end
      if (img_restart) begin
        img_nib <= avs_writedata[`RMH_IMG_NIB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data pins come from another domain; two flops before use
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
    end else begin
      data_s1 <= rom_data;
      data_s2 <= data_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin sequencer; address and selects held until data settle, then a
  // deselect gap so the ROM has floated before any other driver
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase    <= PH_IDLE;
      wait_cnt <= 4'h0;
      sel_act  <= 1'b0;
      rom_addr <= 10'h000;
      done     <= 1'b0;
      byte_q   <= 8'h00;
      fig_q    <= 4'h0;
      index_q  <= 11'h000;
    end else begin
      case (phase)
        PH_IDLE: begin
          // Mode comes from the starting write itself; fig_mode lands too late
          if (start) begin
            rom_addr <= avs_writedata[`RMH_CTRL_FIG] ? index[10:1] : index[9:0];
            index_q  <= avs_writedata[`RMH_CTRL_FIG] ? index : {index[9:0], 1'b0};
            sel_act  <= 1'b1;
            done     <= 1'b0;
            wait_cnt <= 4'h0;
            phase    <= PH_ACCESS;
          end
        end
        PH_ACCESS: begin
          // Access covers both address and select delays plus the sync;
          // one spare cycle so the pins are never sampled right at the limit
          if (wait_cnt == 4'(`RMH_ACC_CYC + `RMH_SYNC_CYC)) begin
            byte_q   <= data_s2;
            fig_q    <= index_q[0] ? data_s2[3:0] : data_s2[7:4];
            sel_act  <= 1'b0;
            wait_cnt <= 4'h0;
            phase    <= PH_HOLD;
          end else begin
            wait_cnt <= 4'(wait_cnt + 4'h1);
          end
        end
        PH_HOLD: begin
          // Selects drop a cycle after this phase starts, so count one more
          if (wait_cnt == 4'(`RMH_DHD_CYC)) begin
            done  <= 1'b1;
            phase <= PH_IDLE;
          end else begin
            wait_cnt <= 4'(wait_cnt + 4'h1);
          end
        end
        default: phase <= PH_IDLE;
      endcase
    end
  end

  // Select pins from the mask options; reset shows the inactive levels
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      select_input_one   <= sel_level(SEL_ONE_CFG, 1'b0);
      select_input_two   <= sel_level(SEL_TWO_CFG, 1'b0);
      select_input_three <= sel_level(SEL_THREE_CFG, 1'b0);
      select_input_four  <= sel_level(SEL_FOUR_CFG, 1'b0);
    end else begin
      select_input_one   <= sel_level(SEL_ONE_CFG, sel_act);
      select_input_two   <= sel_level(SEL_TWO_CFG, sel_act);
      select_input_three <= sel_level(SEL_THREE_CFG, sel_act);
      select_input_four  <= sel_level(SEL_FOUR_CFG, sel_act);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Image format checker
  rmh_image_check u_check (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .chr       (avs_writedata[7:0]),
    .chr_push  (img_push && !img_restart),
    .restart   (img_restart),
    .nib_mode  (img_nib),
    .img_ok    (img_ok),
    .img_err   (img_err),
    .img_lines (img_lines),
    .word_addr (word_addr),
    .word_data (word_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_sel_order;
    @(posedge mclk) disable iff (sys_rst) cfg_ok;
  endproperty
  a_sel_order: assert property (p_sel_order)
    else $error("unconnected select below a connected one");

  property p_fig_pick;
    @(posedge mclk) disable iff (sys_rst)
      $rose(done) |-> fig_q == (index_q[0] ? byte_q[3:0] : byte_q[7:4]);
  endproperty
  a_fig_pick: assert property (p_fig_pick)
    else $error("figure not taken from the right half of the byte");

  property p_line_pos;
    @(posedge mclk) disable iff (sys_rst)
      start && avs_writedata[`RMH_CTRL_FIG]
      |=> index_q == $past(index) && rom_addr == $past(index[10:1]);
  endproperty
  a_line_pos: assert property (p_line_pos)
    else $error("figure index maps to wrong byte");

endmodule
`default_nettype wire

//--- bench/rmh_rom_model.sv
// Behavioural 1024 x 8 mask ROM with four mask-set selects.
// Assumes the host drives address and selects; no clock reaches it.
`timescale 1ns/100ps
`default_nettype none

module rmh_rom_model
  import rmh_pkg::*;
#(
  parameter rmh_sel_t ONE_CFG   = RMH_SEL_HIGH, // Mask level, select one
  parameter rmh_sel_t TWO_CFG   = RMH_SEL_LOW,  // Mask level, select two
  parameter rmh_sel_t THREE_CFG = RMH_SEL_NC,   // Mask level, select three
  parameter rmh_sel_t FOUR_CFG  = RMH_SEL_NC,   // Mask level, select four
  parameter int       T_ACC     = 350,          // Address to data, ns
  parameter int       T_SO      = 150           // Select to data, ns
)(
  input  wire logic [9:0] rom_addr,           // Address pins
  input  wire logic       select_input_one,   // Select 1
  input  wire logic       select_input_two,   // Select 2
  input  wire logic       select_input_three, // Select 3
  input  wire logic       select_input_four,  // Select 4
  output var  logic [7:0] rom_data            // Data pins
);
  logic [7:0] mem [0:1023];
  logic [7:0] junk;
  realtime    t_addr;
  realtime    t_sel;

  function automatic logic pin_ok(input rmh_sel_t c, input logic v);
    pin_ok = (c == RMH_SEL_NC) || (c == RMH_SEL_HIGH && v === 1'b1)
          || (c == RMH_SEL_LOW && v === 1'b0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Customer content, fixed when the model is built
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'(i * 61) ^ 8'(i >> 2);
    end
  end

  // Time of the last level change on each input group
  always @(rom_addr) t_addr = $realtime;
  always @(select_input_one, select_input_two, select_input_three, select_input_four)
    t_sel = $realtime;

  // Level-driven output, sampled off the clock edges; a float shows churn
  initial begin
    junk = 8'hA5;
    #2;
    forever begin
      #5;
      junk = junk + 8'h5B;
      if (pin_ok(ONE_CFG, select_input_one) && pin_ok(TWO_CFG, select_input_two)
          && pin_ok(THREE_CFG, select_input_three) && pin_ok(FOUR_CFG, select_input_four)
          && $realtime >= t_addr + T_ACC && $realtime >= t_sel + T_SO) begin
        rom_data = mem[rom_addr];
      end else begin
        rom_data = junk;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the mask ROM host: Avalon master and ROM model.
// Assumes the host's register map and 1-wait-state bus from its notes.
`timescale 1ns/100ps
`default_nettype none
`include "rmh_map.svh"

module tb_top
  import rmh_pkg::*;
;
  logic        mclk          = 1'b0;
  logic        sys_rst       = 1'b1;
  logic [4:0]  avs_address   = 5'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [9:0]  rom_addr;
  logic        select_input_one;
  logic        select_input_two;
  logic        select_input_three;
  logic        select_input_four;
  logic [7:0]  rom_data;
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  logic [7:0]  last;
  int          errors      = 0;
  int          checks_done = 0;
  int          seed        = 39206;

  // Legal select set: unconnected only at the top
  rmh_rom_host rmh_rom_host_inst (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rom_addr(rom_addr),
    .select_input_one(select_input_one), .select_input_two(select_input_two),
    .select_input_three(select_input_three), .select_input_four(select_input_four),
    .rom_data(rom_data));
  rmh_rom_model rmh_rom_model_inst (
    .rom_addr(rom_addr), .select_input_one(select_input_one),
    .select_input_two(select_input_two), .select_input_three(select_input_three),
    .select_input_four(select_input_four), .rom_data(rom_data));

  initial forever #25 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  // Oldest note against each read answer
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      checks_done++;
      if ((avs_readdata & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
        errors++;
        $display("CHECK FAILED readdata %h exp %h seen %h", avs_address, exp_q[0], avs_readdata);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  task automatic pin(input string n, input logic [10:0] e, input logic [10:0] s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask

  // Bounded wait for waitrequest low at a rising edge
  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    pin("waitrequest", 11'h0, {10'h0, avs_waitrequest});
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
                    output logic [31:0] v);
    exp_q.push_back(e);
    msk_q.push_back(m);
    avs_address <= a;
    avs_read    <= 1'b1;
    wait_ack();
    v = avs_readdata;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One ROM access through the host, pins watched on the way
  task automatic fetch(input logic fig, input logic [10:0] i);
    logic [31:0] v;
    logic [10:0] idx;
    logic [10:0] fi;
    logic [7:0]  b;
    logic [3:0]  f;
    int          n;
    idx = fig ? i : {1'b0, i[9:0]};
    fi  = fig ? idx : {idx[9:0], 1'b0};
    b   = rmh_rom_model_inst.mem[fi[10:1]];
    f   = fi[0] ? b[3:0] : b[7:4];
    wr(`RMH_OFF_ADDR, {21'h0, idx});
    wr(`RMH_OFF_CTRL, {30'h0, fig, 1'b1});
    @(posedge mclk);
    pin("rom_addr", {1'b0, fi[10:1]}, {1'b0, rom_addr});
    pin("sel active", 11'h001, {7'h0, select_input_four, select_input_three,
        select_input_two, select_input_one});
    n = 0;
    v = 32'h0;
    while (v[1] !== 1'b1 && n < 40) begin
      rd(`RMH_OFF_STAT, 32'h0, 32'h0, v);
      n++;
    end
    pin("done", 11'h001, {10'h0, v[1]});
    @(posedge mclk);
    pin("sel idle", 11'h002, {7'h0, select_input_four, select_input_three,
        select_input_two, select_input_one});
    rd(`RMH_OFF_DATA, {9'h0, fi[5:0], fi[10:6], f, b},
       fig ? 32'h007FFF00 : 32'h007FFFFF, v);
  endtask

  // Image walk: kind 0 full bytes, 1 one nibble line, 2 faulty
  task automatic image(input logic nib, input int ids, input int lines, input logic drop_lf,
                       input int kind);
    logic [31:0] v;
    logic [3:0]  f;
    wr(`RMH_OFF_IMG, {22'h0, nib, 1'b1, 8'h0});
    repeat (ids) wr(`RMH_OFF_IMG, 32'h49);
    wr(`RMH_OFF_IMG, 32'h0D);
    wr(`RMH_OFF_IMG, 32'h0A);
    for (int l = 0; l < lines; l++) begin
      for (int k = 0; k < 64; k++) begin
        f = 4'($random(seed));
        last = {last[3:0], f};
        wr(`RMH_OFF_IMG, {24'h0, f < 4'hA ? {4'h0, f} + 8'h30 : {4'h0, f} + 8'h37});
      end
      wr(`RMH_OFF_IMG, 32'h0D);
      if (!(drop_lf && l == lines - 1)) wr(`RMH_OFF_IMG, 32'h0A);
    end
    if (drop_lf) wr(`RMH_OFF_IMG, 32'h41);
    if (kind == 0) rd(`RMH_OFF_IMGST, {5'h0, last, 11'h3FF, 6'h20, 2'b01}, 32'h07FFFFFF, v);
    if (kind == 1) rd(`RMH_OFF_IMGST, {9'h0, last[3:0], 11'h03F, 6'h01, 2'b00}, 32'h07FFFFFF, v);
    if (kind == 2) rd(`RMH_OFF_IMGST, 32'h2, 32'h2, v);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] v;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(`RMH_OFF_CTRL, 32'h0, 32'hFFFFFFFF, v);
    rd(`RMH_OFF_STAT, 32'h4, 32'hFFFFFFFF, v);
    rd(5'h18, 32'h0, 32'hFFFFFFFF, v);
    wr(5'h18, 32'hFFFFFFFF);
    rd(5'h18, 32'h0, 32'hFFFFFFFF, v);
    fetch(1'b0, 11'h000);
    fetch(1'b0, 11'h3FF);
    fetch(1'b1, 11'h001);
    fetch(1'b1, 11'h7FF);
    rd(`RMH_OFF_CTRL, 32'h2, 32'h2, v);
    repeat (6) fetch(1'($random(seed)), 11'($random(seed)));
    image(1'b0, 64, 32, 1'b0, 0);
    image(1'b1, 3, 1, 1'b0, 1);
    image(1'b0, 0, 1, 1'b0, 2);
    image(1'b0, 65, 1, 1'b0, 2);
    image(1'b0, 5, 1, 1'b1, 2);
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(`RMH_OFF_CTRL, 32'h0, 32'hFFFFFFFF, v);
    conclude();
  end

  // Hang guard, well past the expected run
  initial begin
    #1500000;
    errors++;
    $display("CHECK FAILED watchdog exp finish seen timeout");
    conclude();
  end

  task automatic conclude();
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
